// file: inc/regulator_enable_override_pkg.sv
// Purpose: types shared by the rail override register bank
// Assumes: rail order fixed by the rail_on_s field order
// Notes:   packed structs carry grouped rail signals
package regulator_enable_override_pkg;

   typedef logic [7:0] reg_byte_t;

   // one bit per controlled rail, msb first
   typedef struct packed {
      logic termination_ldo;
      logic load_switch_pair_b;
      logic load_switch_a;
      logic linreg_c;
      logic linreg_b;
      logic stepdown_f;
      logic stepdown_e;
      logic stepdown_d;
      logic stepdown_c;
      logic stepdown_b;
      logic stepdown_a;
   } rail_on_s;

   // sequencer requests, derived outside from chip_enable_pin and sleep_state_pins
   typedef struct packed {
      logic termination_ldo;
      logic load_switch_pair_b;
      logic load_switch_a;
      logic stepdown_f;
      logic stepdown_e;
      logic stepdown_d;
      logic stepdown_c;
      logic stepdown_b;
      logic stepdown_a;
   } seq_req_s;

   // forced pwm select per stepdown a..c (d..f have none), 1 = forced pwm, 0 = automatic
   typedef struct packed {
      logic stepdown_c;
      logic stepdown_b;
      logic stepdown_a;
   } pwm_force_s;

endpackage

// file: inc/regulator_enable_override_regs.svh
// Purpose: offsets, field positions and reset values of the rail override registers
// Assumes: 8-bit registers reached through the serial control port's internal access port
// Notes:   definitions only
`ifndef REGULATOR_ENABLE_OVERRIDE_REGS_SVH
`define REGULATOR_ENABLE_OVERRIDE_REGS_SVH

// register offsets
`define OFS_STEPDOWN_MODE_AND_KILL  8'h9c
`define OFS_RAIL_FORCE_ON           8'h9e
`define OFS_SWITCH_TERM_ENABLE_KILL 8'h9f

// stepdown_mode_and_kill fields
`define POS_STEPDOWN_A_KILL_N       0
`define POS_STEPDOWN_B_KILL_N       1
`define POS_STEPDOWN_C_KILL_N       2
`define POS_PWM_FORCE_LSB           3
`define POS_PWM_FORCE_MSB           5
`define MASK_MODE_AND_KILL          8'h3f

// rail_force_on fields
`define POS_STEPDOWN_A_FORCE_ON     0
`define POS_STEPDOWN_B_FORCE_ON     1
`define POS_STEPDOWN_C_FORCE_ON     2
`define POS_STEPDOWN_D_FORCE_ON     3
`define POS_STEPDOWN_E_FORCE_ON     4
`define POS_STEPDOWN_F_FORCE_ON     5
`define POS_LOAD_SWITCH_A_FORCE_ON  6
`define POS_LINREG_B_FORCE_ON       7

// switch_term_enable_kill fields
`define POS_LINREG_C_FORCE_ON       0
`define POS_SWITCH_PAIR_B_FORCE_ON  1
`define POS_TERM_FORCE_ON           3
`define POS_TERM_KILL_N             4
`define POS_LOAD_SWITCH_A_KILL_N    5
`define POS_SWITCH_PAIR_B_KILL_N    6

// reset values
`define RST_RAIL_FORCE_ON           8'h00
`define RST_MODE_AND_KILL_DEFAULT   8'h07
`define RST_SWITCH_TERM_DEFAULT     8'h70
`define REG_ZERO                    8'h00

`endif

// file: logic/regulator_enable_override_regs.sv
// Purpose: rail override register bank deciding each rail's on request and the pwm mode of stepdown_a..c
// Assumes: register access port is synchronous to clk_in; one access per cycle
// Notes:   otp-dependent reset values are parameters
`timescale 1ns/1ps
`include "regulator_enable_override_regs.svh"

module regulator_enable_override_regs
   import regulator_enable_override_pkg::*;
#(
   parameter reg_byte_t MODE_AND_KILL_RST = `RST_MODE_AND_KILL_DEFAULT,
   parameter reg_byte_t SWITCH_TERM_RST   = `RST_SWITCH_TERM_DEFAULT
) (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   // register access from the serial control port
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   input  wire reg_byte_t  reg_addr_in,
   input  wire reg_byte_t  reg_wdata_in,
   output reg_byte_t       reg_rdata_out,
   output logic            reg_rvalid_out,
   // enable requests
   input  wire seq_req_s   seq_req_in,
   input  wire logic       linreg_switch_enable_pin_in,
   // rail controls
   output rail_on_s        rail_on_out,
   output pwm_force_s      pwm_force_out
);

   // reserved bits 7:6 of the first register are read-only zero, so a reset value there is meaningless
   if ((MODE_AND_KILL_RST & ~`MASK_MODE_AND_KILL) != `REG_ZERO) begin : g_bad_rst
      $error("MODE_AND_KILL_RST must keep bits 7:6 at zero");
   end

   // kill_n of stepdown_a..c and both load switches always comes up at 1, whatever the otp image holds
   if ((MODE_AND_KILL_RST[`POS_STEPDOWN_C_KILL_N:`POS_STEPDOWN_A_KILL_N] != 3'h7) ||
       !SWITCH_TERM_RST[`POS_SWITCH_PAIR_B_KILL_N] ||
       !SWITCH_TERM_RST[`POS_LOAD_SWITCH_A_KILL_N]) begin : g_bad_kill_rst
      $error("kill_n reset bits of the stepdown and load switch rails must be one");
   end

   reg_byte_t  mode_kill_q, mode_kill_d;
   reg_byte_t  force_q, force_d;
   reg_byte_t  sw_term_q, sw_term_d;
   reg_byte_t  rdata_d;
   logic       hit_mode, hit_force, hit_sw;
   logic [10:0] kill_v, force_v, req_v, rail_d;

   // address decode; unmapped offsets ignore writes and read zero
   assign hit_mode  = (reg_addr_in == `OFS_STEPDOWN_MODE_AND_KILL);
   assign hit_force = (reg_addr_in == `OFS_RAIL_FORCE_ON);
   assign hit_sw    = (reg_addr_in == `OFS_SWITCH_TERM_ENABLE_KILL);

   // next register values
   assign mode_kill_d = (reg_wr_in && hit_mode) ? (reg_wdata_in & `MASK_MODE_AND_KILL) : mode_kill_q;
   assign force_d     = (reg_wr_in && hit_force) ? reg_wdata_in : force_q;
   assign sw_term_d   = (reg_wr_in && hit_sw) ? reg_wdata_in : sw_term_q;

   // read mux, answered one cycle after the strobe
   assign rdata_d = hit_mode  ? mode_kill_q :
                    hit_force ? force_q :
                    hit_sw    ? sw_term_q : `REG_ZERO;

   // register storage
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         mode_kill_q <= MODE_AND_KILL_RST;
         force_q     <= `RST_RAIL_FORCE_ON;
         sw_term_q   <= SWITCH_TERM_RST;
      end else begin
         mode_kill_q <= mode_kill_d;
         force_q     <= force_d;
         sw_term_q   <= sw_term_d;
      end
   end

   // kill_n per rail; rails without a kill bit hold a constant 1
   assign kill_v = {sw_term_q[`POS_TERM_KILL_N],
                    sw_term_q[`POS_SWITCH_PAIR_B_KILL_N],
                    sw_term_q[`POS_LOAD_SWITCH_A_KILL_N],
                    1'b1, 1'b1,
                    1'b1, 1'b1, 1'b1,
                    mode_kill_q[`POS_STEPDOWN_C_KILL_N],
                    mode_kill_q[`POS_STEPDOWN_B_KILL_N],
                    mode_kill_q[`POS_STEPDOWN_A_KILL_N]};

   // force_on per rail
   assign force_v = {sw_term_q[`POS_TERM_FORCE_ON],
                     sw_term_q[`POS_SWITCH_PAIR_B_FORCE_ON],
                     force_q[`POS_LOAD_SWITCH_A_FORCE_ON],
                     sw_term_q[`POS_LINREG_C_FORCE_ON],
                     force_q[`POS_LINREG_B_FORCE_ON],
                     force_q[`POS_STEPDOWN_F_FORCE_ON],
                     force_q[`POS_STEPDOWN_E_FORCE_ON],
                     force_q[`POS_STEPDOWN_D_FORCE_ON],
                     force_q[`POS_STEPDOWN_C_FORCE_ON],
                     force_q[`POS_STEPDOWN_B_FORCE_ON],
                     force_q[`POS_STEPDOWN_A_FORCE_ON]};

   // normal request: linreg_b and linreg_c follow the pin, the rest the sequencer
   assign req_v = {seq_req_in.termination_ldo,
                   seq_req_in.load_switch_pair_b,
                   seq_req_in.load_switch_a,
                   linreg_switch_enable_pin_in,
                   linreg_switch_enable_pin_in,
                   seq_req_in.stepdown_f,
                   seq_req_in.stepdown_e,
                   seq_req_in.stepdown_d,
                   seq_req_in.stepdown_c,
                   seq_req_in.stepdown_b,
                   seq_req_in.stepdown_a};

   // kill wins over force and request alike
   for (genvar i = 0; i < 11; i++) begin : g_rail
      assign rail_d[i] = kill_v[i] & (force_v[i] | req_v[i]);
   end

   // outputs straight from flops; rails off during reset so nothing glitches on
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rail_on_out    <= '0;
         pwm_force_out  <= '0;
         reg_rdata_out  <= `REG_ZERO;
         reg_rvalid_out <= 1'b0;
      end else begin
         rail_on_out    <= rail_on_s'(rail_d);
         pwm_force_out  <= pwm_force_s'(mode_kill_q[`POS_PWM_FORCE_MSB:`POS_PWM_FORCE_LSB]);
         reg_rdata_out  <= reg_rd_in ? rdata_d : `REG_ZERO;
         reg_rvalid_out <= reg_rd_in;
      end
   end

   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   chk_pwm_mode_follow: assert property (
      ##1 pwm_force_out == $past(mode_kill_q[`POS_PWM_FORCE_MSB:`POS_PWM_FORCE_LSB]))
      else $error("pwm mode output does not follow mode bits");
   chk_kill_a_off: assert property (
      !mode_kill_q[`POS_STEPDOWN_A_KILL_N] |=> !rail_on_out.stepdown_a)
      else $error("stepdown_a on while killed");
   chk_kill_beats_force: assert property (
      force_q[`POS_STEPDOWN_C_FORCE_ON] && !mode_kill_q[`POS_STEPDOWN_C_KILL_N] |=> !rail_on_out.stepdown_c)
      else $error("stepdown_c force beat kill");
   chk_force_b_on: assert property (
      force_q[`POS_STEPDOWN_B_FORCE_ON] && mode_kill_q[`POS_STEPDOWN_B_KILL_N] |=> rail_on_out.stepdown_b)
      else $error("stepdown_b force ignored");
   chk_force_d_on: assert property (
      force_q[`POS_STEPDOWN_D_FORCE_ON] |=> rail_on_out.stepdown_d)
      else $error("stepdown_d force ignored");
   chk_linreg_pin_ctl: assert property (
      !sw_term_q[`POS_LINREG_C_FORCE_ON] |=> rail_on_out.linreg_c == $past(linreg_switch_enable_pin_in))
      else $error("linreg_c does not follow pin");
   chk_switch_kill_off: assert property (
      !sw_term_q[`POS_SWITCH_PAIR_B_KILL_N] |=> !rail_on_out.load_switch_pair_b)
      else $error("load_switch_pair_b on while killed");
   chk_term_force_on: assert property (
      sw_term_q[`POS_TERM_FORCE_ON] && sw_term_q[`POS_TERM_KILL_N] |=> rail_on_out.termination_ldo)
      else $error("termination_ldo force ignored");
   chk_force_rst_zero: assert property (
      $past(sys_rst_in) |-> force_q == `RST_RAIL_FORCE_ON)
      else $error("rail force register not zero after reset");
   chk_kill_rst_one: assert property (
      $past(sys_rst_in) |-> mode_kill_q[`POS_STEPDOWN_C_KILL_N:`POS_STEPDOWN_A_KILL_N] == 3'h7
                            && sw_term_q[`POS_SWITCH_PAIR_B_KILL_N] && sw_term_q[`POS_LOAD_SWITCH_A_KILL_N])
      else $error("kill_n bits not one after reset");
   chk_request_path: assert property (
      seq_req_in.stepdown_e |=> rail_on_out.stepdown_e)
      else $error("stepdown_e request not honoured");
   chk_idle_rail_off: assert property (
      !seq_req_in.stepdown_e && !force_q[`POS_STEPDOWN_E_FORCE_ON] |=> !rail_on_out.stepdown_e)
      else $error("stepdown_e on with neither request nor force");
   chk_kill_b_off: assert property (
      !mode_kill_q[`POS_STEPDOWN_B_KILL_N] |=> !rail_on_out.stepdown_b)
      else $error("stepdown_b on while killed");
   chk_kill_c_off: assert property (
      !mode_kill_q[`POS_STEPDOWN_C_KILL_N] |=> !rail_on_out.stepdown_c)
      else $error("stepdown_c on while killed");
   chk_load_a_kill: assert property (
      !sw_term_q[`POS_LOAD_SWITCH_A_KILL_N] |=> !rail_on_out.load_switch_a)
      else $error("load_switch_a on while killed");
   chk_term_kill_off: assert property (
      !sw_term_q[`POS_TERM_KILL_N] |=> !rail_on_out.termination_ldo)
      else $error("termination_ldo on while killed");
   chk_linreg_b_force: assert property (
      force_q[`POS_LINREG_B_FORCE_ON] |=> rail_on_out.linreg_b)
      else $error("linreg_b force ignored");
   // reserved bits must never hold a written one, or readback would leak it
   chk_mode_reserved_zero: assert property (
      (mode_kill_q & ~`MASK_MODE_AND_KILL) == `REG_ZERO)
      else $error("reserved mode bits not zero");
   chk_write_force: assert property (
      reg_wr_in && hit_force |=> force_q == $past(reg_wdata_in))
      else $error("rail force write lost");
   chk_write_sw_term: assert property (
      reg_wr_in && hit_sw |=> sw_term_q == $past(reg_wdata_in))
      else $error("switch and termination write lost");
   chk_write_mode_mask: assert property (
      reg_wr_in && hit_mode |=> mode_kill_q == ($past(reg_wdata_in) & `MASK_MODE_AND_KILL))
      else $error("mode and kill write lost");
   chk_read_sw_term: assert property (
      reg_rd_in && hit_sw |=> reg_rvalid_out && reg_rdata_out == $past(sw_term_q))
      else $error("switch and termination readback wrong");
   chk_idle_rdata_zero: assert property (
      !reg_rd_in |=> !reg_rvalid_out && reg_rdata_out == `REG_ZERO)
      else $error("read port not idle without a read");

   cov_kill_over_force: cover property (force_q[`POS_STEPDOWN_A_FORCE_ON] && !mode_kill_q[`POS_STEPDOWN_A_KILL_N]);
   cov_linreg_pin_on:   cover property (!force_q[`POS_LINREG_B_FORCE_ON] ##1 rail_on_out.linreg_b);
   cov_write_sw_term:   cover property (reg_wr_in && hit_sw);
   cov_read_back:       cover property (reg_rd_in && hit_mode ##1 reg_rvalid_out);
   cov_all_forced_pwm:  cover property (pwm_force_out == 3'h7);

endmodule

// file: testbench/regulator_enable_override_regs_tb.sv
// Purpose: self-checking bench for the rail override register bank
// Assumes: one-cycle read latency; inputs driven on the falling edge
// Notes:   expected rails come from a bench shadow of the three registers
`timescale 1ns/1ps
`include "regulator_enable_override_regs.svh"

module regulator_enable_override_regs_tb
   import regulator_enable_override_pkg::*;
();
   logic       clk_in;
   logic       sys_rst_in;
   logic       reg_wr_in;
   logic       reg_rd_in;
   reg_byte_t  reg_addr_in;
   reg_byte_t  reg_wdata_in;
   reg_byte_t  reg_rdata_out;
   logic       reg_rvalid_out;
   seq_req_s   seq_req_in;
   logic       linreg_switch_enable_pin_in;
   rail_on_s   rail_on_out;
   pwm_force_s pwm_force_out;
   reg_byte_t  mk_q;
   reg_byte_t  fo_q;
   reg_byte_t  st_q;
   int         n_errors;
   int         n_tests;
   int         cycles;
   int         tnum;

   regulator_enable_override_regs regulator_enable_override_regs_i (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .reg_rvalid_out(reg_rvalid_out), .seq_req_in(seq_req_in),
      .linreg_switch_enable_pin_in(linreg_switch_enable_pin_in),
      .rail_on_out(rail_on_out), .pwm_force_out(pwm_force_out));

   // 40 mhz clock
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   // expected rail enables: kill_n and (force_on or request)
   function automatic rail_on_s exp_rail();
      rail_on_s r;
      r.stepdown_a         = mk_q[0] & (fo_q[0] | seq_req_in.stepdown_a);
      r.stepdown_b         = mk_q[1] & (fo_q[1] | seq_req_in.stepdown_b);
      r.stepdown_c         = mk_q[2] & (fo_q[2] | seq_req_in.stepdown_c);
      r.stepdown_d         = fo_q[3] | seq_req_in.stepdown_d;
      r.stepdown_e         = fo_q[4] | seq_req_in.stepdown_e;
      r.stepdown_f         = fo_q[5] | seq_req_in.stepdown_f;
      r.linreg_b           = fo_q[7] | linreg_switch_enable_pin_in;
      r.linreg_c           = st_q[0] | linreg_switch_enable_pin_in;
      r.load_switch_a      = st_q[5] & (fo_q[6] | seq_req_in.load_switch_a);
      r.load_switch_pair_b = st_q[6] & (st_q[1] | seq_req_in.load_switch_pair_b);
      r.termination_ldo    = st_q[4] & (st_q[3] | seq_req_in.termination_ldo);
      return r;
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // write strobe held across exactly one rising edge; shadow tracks what sticks
   task automatic wr(input reg_byte_t a, input reg_byte_t d);
      @(negedge clk_in);
      reg_wr_in    = 1'b1;
      reg_addr_in  = a;
      reg_wdata_in = d;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
      check({7'h00, reg_rvalid_out, reg_rdata_out}, 16'h0000);
      if (a == `OFS_STEPDOWN_MODE_AND_KILL) mk_q = d & 8'h3f;
      if (a == `OFS_RAIL_FORCE_ON) fo_q = d;
      if (a == `OFS_SWITCH_TERM_ENABLE_KILL) st_q = d;
   endtask

   // read data and valid stand only in the cycle after the strobe
   task automatic rd(input reg_byte_t a, input reg_byte_t exp);
      @(negedge clk_in);
      reg_rd_in   = 1'b1;
      reg_addr_in = a;
      @(negedge clk_in);
      reg_rd_in = 1'b0;
      check({7'h00, reg_rvalid_out, reg_rdata_out}, {8'h01, exp});
   endtask

   task automatic apply(input reg_byte_t m, input reg_byte_t f, input reg_byte_t t,
                        input logic [8:0] s, input logic p);
      wr(`OFS_STEPDOWN_MODE_AND_KILL, m);
      wr(`OFS_RAIL_FORCE_ON, f);
      wr(`OFS_SWITCH_TERM_ENABLE_KILL, t);
      seq_req_in = s;
      linreg_switch_enable_pin_in = p;
      rd(`OFS_STEPDOWN_MODE_AND_KILL, mk_q);
      rd(`OFS_RAIL_FORCE_ON, fo_q);
      rd(`OFS_SWITCH_TERM_ENABLE_KILL, st_q);
      check({5'h00, rail_on_out}, {5'h00, exp_rail()});
      check({13'h0000, pwm_force_out}, {13'h0000, mk_q[5:3]});
      tnum++;
      $display("test %0d done", tnum);
   endtask

   // reset for three cycles; rails must be off meanwhile
   task automatic do_reset();
      @(negedge clk_in);
      sys_rst_in = 1'b1;
      repeat (3) @(negedge clk_in);
      check({5'h00, rail_on_out}, 16'h0000);
      sys_rst_in = 1'b0;
      mk_q = 8'h07;
      fo_q = 8'h00;
      st_q = 8'h70;
      rd(`OFS_STEPDOWN_MODE_AND_KILL, 8'h07);
      rd(`OFS_RAIL_FORCE_ON, 8'h00);
      rd(`OFS_SWITCH_TERM_ENABLE_KILL, 8'h70);
      check({5'h00, rail_on_out}, {5'h00, exp_rail()});
      $display("reset test done");
   endtask

   task automatic summarize();
      $display("comparisons=%0d mismatches=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // hang guard: the sequence needs well under a thousand cycles
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         summarize();
      end
   end

   // main sequence
   initial begin
      {sys_rst_in, reg_wr_in, reg_rd_in} = 3'b100;
      {reg_addr_in, reg_wdata_in, seq_req_in, linreg_switch_enable_pin_in} = '0;
      {n_errors, n_tests, cycles, tnum} = '0;
      do_reset();
      apply(8'h07, 8'h3f, 8'h70, 9'h000, 1'b0);
      apply(8'h00, 8'h3f, 8'h70, 9'h1ff, 1'b0);
      apply(8'hff, 8'h00, 8'h70, 9'h1ff, 1'b0);
      for (int i = 0; i < 3; i++) begin
         apply(8'h07 | (8'h08 << i), 8'h00, 8'h70, 9'h000, 1'b0);
      end
      apply(8'h07, 8'h00, 8'h70, 9'h000, 1'b1);
      apply(8'h07, 8'h80, 8'h01, 9'h000, 1'b0);
      apply(8'h07, 8'h40, 8'h0a, 9'h1c0, 1'b0);
      apply(8'h07, 8'h40, 8'h7a, 9'h000, 1'b0);
      apply(8'h07, 8'h00, 8'hf4, 9'h1c0, 1'b0);
      wr(8'h9d, 8'hff);
      rd(8'h9d, 8'h00);
      apply(8'h03, 8'h3f, 8'h70, 9'h1ff, 1'b1);
      do_reset();
      summarize();
   end
endmodule
